// file: rtl/fal_consts.vh
// Constants for the fuse autoload controller.
`ifndef FAL_CONSTS_VH
`define FAL_CONSTS_VH
`define FAL_DATA_W      32
`define FAL_CODE_W      7
`define FAL_WORD_W      39
`define FAL_ADDR_W      5
`define FAL_NUM_WORDS   6'h20
`define FAL_LAST_ADDR   5'h1f
`define FAL_ROM_LAT     2'h2
`define FAL_WB_LAT      2'h1
`define FAL_RST_HOLD    4'h8
`define FAL_ST_PATTERN  32'ha5c3_0f96
`define FAL_ST_FLIP_BIT 6'h0b
`endif

// file: rtl/fal_single_correct_double_detect_code.v
// Single-error-correct, double-error-detect decoder for one fuse word.
`timescale 1ns/100ps
`default_nettype none
`include "fal_consts.vh"
module fal_single_correct_double_detect_code (
    // Coded word in.
    input  wire [`FAL_WORD_W-1:0] i_word,
    // Decoded result.
    output wire [`FAL_DATA_W-1:0] o_data,
    output wire                   o_single,
    output wire                   o_double
);
    // Hamming(38,32) with an overall parity bit at position 0.
    // Codeword positions 1..38; powers of two hold check bits.
    reg [38:0] code;
    reg [5:0]  syn;
    reg        ovr;
    reg [38:0] fixed;
    reg [31:0] dat;
    integer    p;
    integer    k;
    always @* begin
        code  = i_word;
        syn   = 6'h00;
        ovr   = ^code;
        for (p = 1; p < 39; p = p + 1) begin
            if (code[p]) begin
                syn = syn ^ p[5:0];
            end
        end
        fixed = code;
        if (syn != 6'h00 && ovr && syn < 6'd39) begin
            fixed[syn] = ~fixed[syn];
        end
        dat = 32'h0000_0000;
        k   = 0;
        for (p = 1; p < 39; p = p + 1) begin
            if ((p & (p - 1)) != 0) begin
                dat[k] = fixed[p];
                k = k + 1;
            end
        end
    end
    assign o_data   = dat;
    // A syndrome pointing past the word with odd overall parity means three or more flips.
    assign o_single = ovr && (syn < 6'd39);
    assign o_double = ((syn != 6'h00) && !ovr) || (ovr && (syn > 6'd38));
endmodule // fal_single_correct_double_detect_code
`default_nettype wire

// file: rtl/fal_loader.v
// Fuse autoload controller with coding self-test and reset control.
`timescale 1ns/100ps
`default_nettype none
`include "fal_consts.vh"
module fal_loader (
    // Clock and reset.
    input  wire                   i_ref_clk,
    input  wire                   i_sys_rst,
    // Fuse ROM read port.
    output reg  [`FAL_ADDR_W-1:0] o_rom_addr,
    output reg                    o_rom_rd,
    input  wire [`FAL_WORD_W-1:0] i_rom_word,
    // Destination configuration registers with read back.
    output reg  [`FAL_ADDR_W-1:0] o_cfg_addr,
    output reg  [`FAL_DATA_W-1:0] o_cfg_data,
    output reg                    o_cfg_we,
    input  wire [`FAL_DATA_W-1:0] i_cfg_rdata,
    // Status and reset control.
    output reg                    o_error_status_indication,
    output reg                    o_selftest_fail_flag,
    output reg                    o_ecc_corrected,
    output reg                    o_device_rst,
    output reg                    o_load_done
);
    localparam ST_TEST0 = 3'h0;
    localparam ST_TEST1 = 3'h1;
    localparam ST_READ  = 3'h2;
    localparam ST_WAIT  = 3'h3;
    localparam ST_WRITE = 3'h4;
    localparam ST_CHECK = 3'h5;
    localparam ST_HOLD  = 3'h6;
    localparam ST_DONE  = 3'h7;

    // Encoder used only for the self-test pattern.
    function [`FAL_WORD_W-1:0] fal_encode;
        input [`FAL_DATA_W-1:0] d;
        reg   [38:0] c;
        reg   [5:0]  s;
        integer      q;
        integer      j;
        begin
            c = 39'h0;
            j = 0;
            for (q = 1; q < 39; q = q + 1) begin
                if ((q & (q - 1)) != 0) begin
                    c[q] = d[j];
                    j = j + 1;
                end
            end
            s = 6'h00;
            for (q = 1; q < 39; q = q + 1) begin
                if (c[q]) begin
                    s = s ^ q[5:0];
                end
            end
            for (q = 0; q < 6; q = q + 1) begin
                c[1 << q] = s[q];
            end
            c[0] = ^c;
            fal_encode = c;
        end
    endfunction

    reg  [2:0]             state_reg;
    reg  [2:0]             state_next;
    reg  [`FAL_ADDR_W-1:0] addr_reg;
    reg  [1:0]             lat_reg;
    reg  [3:0]             hold_reg;
    reg                    st_fail_reg;
    reg  [`FAL_DATA_W-1:0] data_reg;
    reg  [`FAL_WORD_W-1:0] dec_in;
    wire [`FAL_DATA_W-1:0] dec_data;
    wire                   dec_single;
    wire                   dec_double;
    wire [`FAL_WORD_W-1:0] st_good;
    wire [`FAL_WORD_W-1:0] st_single;
    wire [`FAL_WORD_W-1:0] st_double;

    assign st_good   = fal_encode(`FAL_ST_PATTERN);
    assign st_single = st_good ^ ({{(`FAL_WORD_W-1){1'b0}}, 1'b1}
                       << `FAL_ST_FLIP_BIT);
    assign st_double = st_single ^ {{(`FAL_WORD_W-1){1'b0}}, 1'b1};

    // Outside self-test the decoder sees only the stored data word; addressing is unprotected.
    always @* begin
        case (state_reg)
            ST_TEST0: dec_in = st_single;
            ST_TEST1: dec_in = st_double;
            default:  dec_in = i_rom_word;
        endcase
    end

    // The decoder has no enable; it checks every word it is handed.
    fal_single_correct_double_detect_code u_dec (
        .i_word   (dec_in),
        .o_data   (dec_data),
        .o_single (dec_single),
        .o_double (dec_double)
    );

    // No control input reaches this machine besides reset.
    always @* begin
        state_next = state_reg;
        case (state_reg)
            ST_TEST0: begin
                if (dec_double || dec_data != `FAL_ST_PATTERN) begin
                    state_next = ST_HOLD;
                end else begin
                    state_next = ST_TEST1;
                end
            end
            ST_TEST1: begin
                if (!dec_double) begin
                    state_next = ST_HOLD;
                end else begin
                    state_next = ST_READ;
                end
            end
            ST_READ:  state_next = ST_WAIT;
            ST_WAIT: begin
                if (lat_reg == `FAL_ROM_LAT) begin
                    if (dec_double) begin
                        state_next = ST_HOLD;
                    end else begin
                        state_next = ST_WRITE;
                    end
                end
            end
            ST_WRITE: state_next = ST_CHECK;
            ST_CHECK: begin
                // Compare only once the write has landed in its register.
                if (lat_reg != `FAL_WB_LAT) begin
                    state_next = ST_CHECK;
                end else if (i_cfg_rdata != data_reg) begin
                    state_next = ST_HOLD;
                end else if (addr_reg == `FAL_LAST_ADDR) begin
                    state_next = ST_DONE;
                end else begin
                    state_next = ST_READ;
                end
            end
            ST_HOLD: begin
                if (hold_reg == `FAL_RST_HOLD) begin
                    state_next = ST_TEST0;
                end
            end
            default:  state_next = ST_DONE;
        endcase
    end

    always @(posedge i_ref_clk) begin
        if (i_sys_rst) begin
            state_reg                 <= ST_TEST0;
            addr_reg                  <= 5'h00;
            lat_reg                   <= 2'h0;
            hold_reg                  <= 4'h0;
            st_fail_reg               <= 1'b0;
            data_reg                  <= 32'h0000_0000;
            o_rom_addr                <= 5'h00;
            o_rom_rd                  <= 1'b0;
            o_cfg_addr                <= 5'h00;
            o_cfg_data                <= 32'h0000_0000;
            o_cfg_we                  <= 1'b0;
            o_error_status_indication <= 1'b0;
            o_selftest_fail_flag      <= 1'b0;
            o_ecc_corrected           <= 1'b0;
            o_device_rst              <= 1'b1;
            o_load_done               <= 1'b0;
        end else begin
            state_reg <= state_next;
            o_rom_rd  <= 1'b0;
            o_cfg_we  <= 1'b0;
            if (state_reg == ST_HOLD) begin
                hold_reg <= hold_reg + 4'h1;
            end else begin
                hold_reg <= 4'h0;
            end
            if (state_reg == ST_WAIT || state_reg == ST_CHECK) begin
                lat_reg <= lat_reg + 2'h1;
            end else begin
                lat_reg <= 2'h0;
            end
            if (state_reg == ST_TEST0 && state_next == ST_HOLD) begin
                st_fail_reg <= 1'b1;
            end
            if (state_reg == ST_TEST1 && state_next == ST_HOLD) begin
                st_fail_reg <= 1'b1;
            end
            if (state_reg == ST_TEST1 && state_next == ST_READ) begin
                st_fail_reg <= 1'b0;
                addr_reg    <= 5'h00;
            end
            // Flag mirrors the latest self-test outcome.
            o_selftest_fail_flag <= st_fail_reg;
            if (state_reg == ST_READ) begin
                o_rom_addr <= addr_reg;
                o_rom_rd   <= 1'b1;
            end
            if (state_reg == ST_WAIT && lat_reg == `FAL_ROM_LAT) begin
                data_reg <= dec_data;
                if (dec_single) begin
                    o_ecc_corrected <= 1'b1;
                end
            end
            if (state_reg == ST_WRITE) begin
                o_cfg_addr <= addr_reg;
                o_cfg_data <= data_reg;
                o_cfg_we   <= 1'b1;
            end
            if (state_reg == ST_CHECK && state_next == ST_READ) begin
                addr_reg <= addr_reg + 5'h01;
            end
            // Sticky until a clean load completes.
            if (state_next == ST_HOLD) begin
                o_error_status_indication <= 1'b1;
            end else if (state_next == ST_DONE) begin
                o_error_status_indication <= o_ecc_corrected;
            end
            o_device_rst <= (state_next != ST_DONE);
            o_load_done  <= (state_next == ST_DONE);
            if (state_reg == ST_HOLD && state_next == ST_TEST0) begin
                o_ecc_corrected <= 1'b0;
            end
        end
    end
endmodule // fal_loader
`default_nettype wire

// file: tb/fal_loader_checker.sv
// Concurrent assertions on the fuse autoload controller ports.
`timescale 1ns/100ps
`default_nettype none
`include "fal_consts.vh"
module fal_loader_checker (
    // Clock and reset.
    input wire                   i_ref_clk,
    input wire                   i_sys_rst,
    // Fuse ROM side.
    input wire [`FAL_ADDR_W-1:0] o_rom_addr,
    input wire                   o_rom_rd,
    input wire [`FAL_WORD_W-1:0] i_rom_word,
    // Destination side.
    input wire [`FAL_ADDR_W-1:0] o_cfg_addr,
    input wire [`FAL_DATA_W-1:0] o_cfg_data,
    input wire                   o_cfg_we,
    input wire [`FAL_DATA_W-1:0] i_cfg_rdata,
    // Status.
    input wire                   o_error_status_indication,
    input wire                   o_selftest_fail_flag,
    input wire                   o_ecc_corrected,
    input wire                   o_device_rst,
    input wire                   o_load_done
);
    default clocking dc @(posedge i_ref_clk); endclocking
    default disable iff (i_sys_rst);
    a_write_source: assert property (o_cfg_we |-> $past(o_rom_rd, 4))
        else $error("write without a read four cycles before");
    a_write_addr: assert property
        (o_cfg_we |-> o_cfg_addr == $past(o_rom_addr, 4))
        else $error("write address differs from read address");
    a_done_last: assert property
        ($rose(o_load_done) |-> $past(o_cfg_addr) == 5'h1f)
        else $error("load finished before the last word");
    a_rst_pairs: assert property (o_device_rst == !o_load_done)
        else $error("device reset and done disagree");
    a_start_read: assert property
        ($fell(i_sys_rst) |-> ##[1:8] (o_rom_rd && o_rom_addr == 5'h00))
        else $error("no first read after reset");
    a_fail_hold: assert property
        ($rose(o_error_status_indication) && !o_ecc_corrected && !o_load_done
         |-> o_device_rst [*8])
        else $error("reset not held after failure");
    a_fail_reload: assert property
        ($rose(o_error_status_indication) && !o_ecc_corrected && !o_load_done
         |-> ##[1:40] (o_rom_rd && o_rom_addr == 5'h00))
        else $error("load not restarted after failure");
    a_selftest_flag: assert property
        (o_selftest_fail_flag |-> o_error_status_indication && o_device_rst)
        else $error("self-test failure not reported");
    a_done_status: assert property
        (o_load_done |-> o_error_status_indication == o_ecc_corrected)
        else $error("status at done differs from corrected flag");
endmodule // fal_loader_checker
bind fal_loader fal_loader_checker fal_loader_checker_i (
    .i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst), .o_rom_addr(o_rom_addr),
    .o_rom_rd(o_rom_rd), .i_rom_word(i_rom_word), .o_cfg_addr(o_cfg_addr),
    .o_cfg_data(o_cfg_data), .o_cfg_we(o_cfg_we), .i_cfg_rdata(i_cfg_rdata),
    .o_error_status_indication(o_error_status_indication),
    .o_selftest_fail_flag(o_selftest_fail_flag),
    .o_ecc_corrected(o_ecc_corrected), .o_device_rst(o_device_rst),
    .o_load_done(o_load_done));
`default_nettype wire

// file: tb/fal_rom_model.sv
// Behavioural fuse ROM with coded words and fault injection.
`timescale 1ns/100ps
`default_nettype none
`include "fal_consts.vh"
module fal_rom_model (
    input  wire                   i_ref_clk,
    input  wire [`FAL_ADDR_W-1:0] i_rom_addr,
    input  wire                   i_rom_rd,
    input  wire [`FAL_ADDR_W-1:0] i_flip_addr,
    input  wire [`FAL_WORD_W-1:0] i_flip_mask,
    output wire [`FAL_WORD_W-1:0] o_rom_word
);
    reg  [4:0]  addr_reg = 5'h00;
    reg  [3:0]  sh_reg   = 4'h0;
    reg  [38:0] last_reg = 39'h0;
    wire        valid    = |sh_reg[3:1];
    wire [38:0] word_now;
    function automatic logic [31:0] dat(input logic [4:0] a);
        dat = {4{a, 3'h5}};
    endfunction
    // Check bit p covers every position with bit p set; bit 0 is parity.
    function automatic logic [38:0] enc(input logic [31:0] d);
        int i;
        int k;
        logic [38:0] w;
        w = 39'h0;
        k = 0;
        for (i = 1; i < 39; i++) if ((i & (i - 1)) != 0) begin
            w[i] = d[k];
            k++;
        end
        for (i = 0; i < 6; i++)
            for (k = 1; k < 39; k++)
                if (((k >> i) & 1) != 0 && k != (1 << i)) w[1 << i] ^= w[k];
        w[0] = ^w[38:1];
        enc = w;
    endfunction
    assign word_now = enc(dat(addr_reg))
        ^ ((addr_reg == i_flip_addr) ? i_flip_mask : 39'h0);
    always @(posedge i_ref_clk) begin
        sh_reg <= {sh_reg[2:0], i_rom_rd};
        if (i_rom_rd) addr_reg <= i_rom_addr;
        if (valid) last_reg <= word_now;
    end
    // Outside the read window the lines show no stale word.
    assign o_rom_word = valid ? word_now : ~last_reg;
endmodule // fal_rom_model
`default_nettype wire

// file: tb/tb_top.sv
// Self-checking testbench for the fuse autoload controller.
`timescale 1ns/100ps
`default_nettype none
`include "fal_consts.vh"
module tb_top;
    logic        i_ref_clk = 1'b0;
    logic        i_sys_rst = 1'b1;
    logic [4:0]  o_rom_addr, o_cfg_addr, flip_addr = 5'h00, wr_next = 5'h00;
    logic        o_rom_rd, o_cfg_we, o_err, o_st, o_corr, o_drst, o_done;
    logic        rb_bad = 1'b0;
    logic [38:0] i_rom_word, flip_mask = 39'h0;
    logic [31:0] o_cfg_data, i_cfg_rdata, mem [0:31];
    int          bad_count = 0, samples_checked = 0;
    initial forever #5 i_ref_clk = ~i_ref_clk;
    fal_rom_model fal_rom_model_i (.i_ref_clk(i_ref_clk),
        .i_rom_addr(o_rom_addr), .i_rom_rd(o_rom_rd), .i_flip_addr(flip_addr),
        .i_flip_mask(flip_mask), .o_rom_word(i_rom_word));
    fal_loader fal_loader_i (.i_ref_clk(i_ref_clk), .i_sys_rst(i_sys_rst),
        .o_rom_addr(o_rom_addr), .o_rom_rd(o_rom_rd), .i_rom_word(i_rom_word),
        .o_cfg_addr(o_cfg_addr), .o_cfg_data(o_cfg_data), .o_cfg_we(o_cfg_we),
        .i_cfg_rdata(i_cfg_rdata), .o_error_status_indication(o_err),
        .o_selftest_fail_flag(o_st), .o_ecc_corrected(o_corr),
        .o_device_rst(o_drst), .o_load_done(o_done));
    assign i_cfg_rdata = mem[o_cfg_addr]
        ^ {31'h0, rb_bad && o_cfg_addr == 5'h03};
    task automatic chk(input string nm, input logic [38:0] e, g);
        samples_checked++;
        if (g !== e) begin
            $display("MISMATCH %s expected %h seen %h", nm, e, g);
            bad_count++;
        end
    endtask
    always @(posedge i_ref_clk) if (!i_sys_rst && o_cfg_we) begin
        mem[o_cfg_addr] <= o_cfg_data;
        wr_next <= o_cfg_addr + 5'h01;
        chk("order", 39'h1, o_cfg_addr == wr_next || ~|o_cfg_addr);
    end
    task automatic tally_and_finish();
        $display("compared %0d mismatches %0d", samples_checked, bad_count);
        if (bad_count == 0 && samples_checked > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask
    task automatic do_reset();
        @(posedge i_ref_clk);
        i_sys_rst <= 1'b1;
        for (int i = 0; i < 32; i++) mem[i] = 32'hffff_ffff;
        repeat (6) @(posedge i_ref_clk);
        i_sys_rst <= 1'b0;
    endtask
    task automatic wait_for(input bit want_done);
        for (int n = 0; n < 3000; n++) begin
            @(posedge i_ref_clk);
            #1;
            if ((want_done ? o_done : o_err) === 1'b1) return;
        end
        chk("wait", 39'h1, 39'h0);
        tally_and_finish();
    endtask
    task automatic t_clean();
        do_reset();
        wait_for(1'b1);
        for (int a = 0; a < 32; a++)
            chk("cfg", fal_rom_model_i.dat(a[4:0]), mem[a]);
        chk("err", 39'h0, o_err);
        chk("corr", 39'h0, o_corr);
        chk("st", 39'h0, o_st);
        chk("drst", 39'h0, o_drst);
    endtask
    task automatic t_single();
        flip_addr <= 5'h05;
        flip_mask <= 39'h10_0000;
        do_reset();
        wait_for(1'b1);
        chk("cfg5", fal_rom_model_i.dat(5'h05), mem[5]);
        chk("corr", 39'h1, o_corr);
        chk("err", 39'h1, o_err);
    endtask
    task automatic t_fail(input bit rb);
        flip_addr <= 5'h09;
        flip_mask <= rb ? 39'h0 : 39'h28;
        rb_bad <= rb;
        do_reset();
        wait_for(1'b0);
        chk("drst", 39'h1, o_drst);
        chk("done", 39'h0, o_done);
        @(posedge i_ref_clk);
        flip_mask <= 39'h0;
        rb_bad <= 1'b0;
        wait_for(1'b1);
        chk("cfg9", fal_rom_model_i.dat(5'h09), mem[9]);
        chk("cfg3", fal_rom_model_i.dat(5'h03), mem[3]);
    endtask
    initial begin
        t_clean();
        t_single();
        t_fail(1'b0);
        t_fail(1'b1);
        tally_and_finish();
    end
endmodule // tb_top
`default_nettype wire
